/* File: rtl/wcs_regs.sv */
`timescale 1ns/1ps
// Overview of operation
// - window code selects fast/slow timeout pair
// - dither-off bit disables converter dithering
// - validation code selects 2,4,6,8 counts
// - edge code selects 4,6,8,10 edges
// - nominal is edges times 2 ms, upper/lower limits are nominal plus/minus deltas
// - enabled fault pulls reset output low 2ms
// - tolerance code allows 0,2,4,8 wrong answers
// - answer window code selects min/max times
// - random six-bit question, upper bits zero
// - random word register readable, writable, zero reset
// - first result register holds four rail flags
// - result flags read-only, write one clears
// - second register bit 7 overall pass
// - second register bit 6 thermal pass
// - second register holds three more rail flags
// - both config registers writable, reset zero
// - type select: pulse, window, or Q&A
// - deltas 0.08 to 0.15 ms, 0.01 steps
module wcs_regs #(
  parameter int RST_LOW_CYCLES = wcs_pkg::POR_LOW_CYCLES
) (
  input wire logic CLK,
  input wire logic NRST,
  input wcs_pkg::wcs_req_t REG_REQ,
  output logic [7:0] REG_RDATA,
  input wire logic [1:0] WATCHDOG_TYPE_SELECT,
  input wire logic [2:0] UPPER_LIMIT_DELTA,
  input wire logic [2:0] LOWER_LIMIT_DELTA,
  input wire logic QA_NEW_QUESTION,
  input wire logic QA_WRONG_ANSWER,
  input wire logic QA_TIMEOUT,
  input wire logic WIN_FAULT,
  input wire logic [7:0] ST_LOW_PASS,
  input wire logic [7:0] ST_HIGH_PASS,
  output wcs_pkg::wcs_timing_t TIMING,
  output logic DITHER_OFF,
  output logic WD_FAULT,
  output logic POWER_ON_RESET_OUT_N
);
  import wcs_pkg::*;

  // ------------------------------------------------------------
  // decode functions
  // ------------------------------------------------------------
  // fast timeout of the window watchdog
  function automatic logic [16:0] win_fast(input logic [2:0] c);
    case (c)
      3'h0: win_fast = 17'h001F4;
      3'h1: win_fast = 17'h003E8;
      3'h2: win_fast = 17'h007D0;
      3'h3: win_fast = 17'h00FA0;
      3'h4: win_fast = 17'h01770;
      3'h5: win_fast = 17'h01F40;
      3'h6: win_fast = 17'h02710;
      default: win_fast = 17'h030D4;
    endcase
  endfunction

  // slow timeout of the window watchdog
  function automatic logic [16:0] win_slow(input logic [2:0] c);
    case (c)
      3'h0: win_slow = 17'h00FA0;
      3'h1: win_slow = 17'h01F40;
      3'h2: win_slow = 17'h03E80;
      3'h3: win_slow = 17'h07D00;
      3'h4: win_slow = 17'h0A410;
      3'h5: win_slow = 17'h0FA00;
      3'h6: win_slow = 17'h13880;
      default: win_slow = 17'h186A0;
    endcase
  endfunction

  // open time of the answer window, in 0.5 ms units
  function automatic logic [9:0] qa_halfms(input logic [3:0] c);
    case (c)
      4'h0: qa_halfms = 10'h001;
      4'h1: qa_halfms = 10'h002;
      4'h2: qa_halfms = 10'h004;
      4'h3: qa_halfms = 10'h008;
      4'h4: qa_halfms = 10'h010;
      4'h5: qa_halfms = 10'h018;
      4'h6: qa_halfms = 10'h020;
      4'h7: qa_halfms = 10'h030;
      4'h8: qa_halfms = 10'h040;
      4'h9: qa_halfms = 10'h050;
      4'hA: qa_halfms = 10'h080;
      4'hB: qa_halfms = 10'h090;
      4'hC: qa_halfms = 10'h0A0;
      4'hD: qa_halfms = 10'h0C0;
      4'hE: qa_halfms = 10'h100;
      default: qa_halfms = 10'h120;
    endcase
  endfunction

  // two-bit code to count of 2,4,6,8 (or 4..10 with offset)
  function automatic logic [3:0] even_count(input logic [1:0] c,
                                             input logic [3:0] base);
    even_count = base + {1'b0, c, 1'b0};
  endfunction

  // delta code to microseconds
  function automatic logic [15:0] delta_us(input logic [2:0] c);
    delta_us = 16'(DELTA_BASE_US + DELTA_STEP_US * int'(c));
  endfunction

  // watchdog type from the select bits
  function automatic wcs_wd_type_t wd_type(input logic [1:0] s);
    if (!s[1]) begin
      wd_type = WD_PULSE;
    end else if (s[0]) begin
      wd_type = WD_QA;
    end else begin
      wd_type = WD_WINDOW;
    end
  endfunction

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0] timing_cfg_reg; // watchdog_timing_config
  logic [7:0] qa_cfg_reg; // qa_watchdog_config
  logic [5:0] random_reg; // random_question_word
  logic [7:0] st_low_reg; // selftest_result_low
  logic [7:0] st_high_reg; // selftest_result_high
  logic [5:0] lfsr_reg; // free running question source
  logic [3:0] wrong_reg; // wrong answers counted
  logic [31:0] low_cnt_reg; // reset output low time
  wcs_rst_state_t rst_state_reg;
  logic wr_timing, wr_qa, wr_rand, wr_low, wr_high;
  logic [3:0] tolerance;
  logic qa_over;
  wcs_wd_type_t active_type;

  // write decode
  assign wr_timing = REG_REQ.wr && (REG_REQ.addr == ADDR_TIMING_CFG);
  assign wr_qa = REG_REQ.wr && (REG_REQ.addr == ADDR_QA_CFG);
  assign wr_rand = REG_REQ.wr && (REG_REQ.addr == ADDR_RANDOM);
  assign wr_low = REG_REQ.wr && (REG_REQ.addr == ADDR_ST_LOW);
  assign wr_high = REG_REQ.wr && (REG_REQ.addr == ADDR_ST_HIGH);

  // configuration registers
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      timing_cfg_reg <= RESET_VALUE;
      qa_cfg_reg <= RESET_VALUE;
    end else begin
      if (wr_timing) begin
        timing_cfg_reg <= REG_REQ.wdata;
      end
      if (wr_qa) begin
        qa_cfg_reg <= REG_REQ.wdata & MASK_QA_CFG;
      end
    end
  end

  // question generator, taps for a maximal six-bit sequence
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      lfsr_reg <= LFSR_SEED;
    end else begin
      lfsr_reg <= {lfsr_reg[4:0], lfsr_reg[5] ^ lfsr_reg[4]};
    end
  end

  // random word: a new question wins over a host write
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      random_reg <= MASK_RANDOM[5:0] & RESET_VALUE[5:0];
    end else if (QA_NEW_QUESTION) begin
      random_reg <= lfsr_reg;
    end else if (wr_rand) begin
      random_reg <= REG_REQ.wdata[5:0];
    end
  end

  // self-test flags: pass sets, write one clears, set wins
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_low_reg <= RESET_VALUE;
      st_high_reg <= RESET_VALUE;
    end else begin
      st_low_reg <= ST_LOW_PASS |
                    (st_low_reg & ~({8{wr_low}} & REG_REQ.wdata));
      st_high_reg <= ST_HIGH_PASS |
                     (st_high_reg & ~({8{wr_high}} & REG_REQ.wdata));
    end
  end

  // read data, registered; unmapped reads zero
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      REG_RDATA <= RESET_VALUE;
    end else if (REG_REQ.rd) begin
      case (REG_REQ.addr)
        ADDR_TIMING_CFG: REG_RDATA <= timing_cfg_reg;
        ADDR_QA_CFG: REG_RDATA <= qa_cfg_reg;
        ADDR_RANDOM: REG_RDATA <= {2'b00, random_reg};
        ADDR_ST_LOW: REG_RDATA <= st_low_reg;
        ADDR_ST_HIGH: REG_RDATA <= st_high_reg;
        default: REG_RDATA <= RESET_VALUE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // decoded settings
  // ------------------------------------------------------------
  // registered so the engines see stable values
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      TIMING <= '0;
      DITHER_OFF <= 1'b0;
    end else begin
      TIMING.win_fast_us <= win_fast(timing_cfg_reg[WIN_SEL_LSB +: 3]);
      TIMING.win_slow_us <= win_slow(timing_cfg_reg[WIN_SEL_LSB +: 3]);
      TIMING.valid_counts <=
        even_count(timing_cfg_reg[VALID_LSB +: 2], 4'h2);
      TIMING.edge_counts <=
        even_count(timing_cfg_reg[EDGE_LSB +: 2], 4'h4);
      TIMING.nominal_us <= 16'(EDGE_PERIOD_US *
        int'(even_count(timing_cfg_reg[EDGE_LSB +: 2], 4'h4)));
      TIMING.upper_us <= 16'(EDGE_PERIOD_US *
        int'(even_count(timing_cfg_reg[EDGE_LSB +: 2], 4'h4))) +
        delta_us(UPPER_LIMIT_DELTA);
      TIMING.lower_us <= 16'(EDGE_PERIOD_US *
        int'(even_count(timing_cfg_reg[EDGE_LSB +: 2], 4'h4))) -
        delta_us(LOWER_LIMIT_DELTA);
      TIMING.wrong_answer_tolerance <= tolerance;
      TIMING.qa_min_us <=
        19'(500 * int'(qa_halfms(qa_cfg_reg[QA_WIN_LSB +: 4])));
      TIMING.qa_max_us <=
        19'(1000 * int'(qa_halfms(qa_cfg_reg[QA_WIN_LSB +: 4])));
      DITHER_OFF <= timing_cfg_reg[DITHER_BIT];
    end
  end

  // tolerance 0,2,4,8
  always_comb begin
    case (qa_cfg_reg[TOL_LSB +: 2])
      2'b00: tolerance = 4'h0;
      2'b01: tolerance = 4'h2;
      2'b10: tolerance = 4'h4;
      default: tolerance = 4'h8;
    endcase
  end

  // ------------------------------------------------------------
  // fault detection
  // ------------------------------------------------------------
  assign active_type = wd_type(WATCHDOG_TYPE_SELECT);
  assign qa_over = QA_WRONG_ANSWER && (wrong_reg >= tolerance);

  // wrong answer counter, cleared by a fault
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wrong_reg <= 4'h0;
    end else if (active_type != WD_QA || WD_FAULT) begin
      wrong_reg <= 4'h0;
    end else if (QA_WRONG_ANSWER) begin
      wrong_reg <= wrong_reg + 4'h1;
    end
  end

  // fault pulse, one cycle
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      WD_FAULT <= 1'b0;
    end else begin
      case (active_type)
        WD_QA: WD_FAULT <= qa_over || QA_TIMEOUT;
        WD_WINDOW: WD_FAULT <= WIN_FAULT;
        default: WD_FAULT <= 1'b0;
      endcase
    end
  end

  // reset output pulse
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rst_state_reg <= RST_IDLE;
      low_cnt_reg <= '0;
    end else begin
      case (rst_state_reg)
        RST_IDLE: begin
          if (WD_FAULT && qa_cfg_reg[RST_EN_BIT]) begin
            rst_state_reg <= RST_LOW;
            low_cnt_reg <= 32'(RST_LOW_CYCLES - 1);
          end
        end
        RST_LOW: begin
          if (low_cnt_reg == '0) begin
            rst_state_reg <= RST_IDLE;
          end else begin
            low_cnt_reg <= low_cnt_reg - 32'h1;
          end
        end
        default: rst_state_reg <= RST_IDLE;
      endcase
    end
  end

  assign POWER_ON_RESET_OUT_N = (rst_state_reg != RST_LOW);

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  a_rst_low_start: assert property (
    WD_FAULT && qa_cfg_reg[RST_EN_BIT] && POWER_ON_RESET_OUT_N
    |=> !POWER_ON_RESET_OUT_N)
    else $error("reset output did not go low on fault");
  a_rst_ignored: assert property (
    $rose(!POWER_ON_RESET_OUT_N) |-> $past(qa_cfg_reg[RST_EN_BIT]))
    else $error("reset output went low while disabled");
  a_random_top_zero: assert property (
    REG_REQ.rd && REG_REQ.addr == ADDR_RANDOM |=> REG_RDATA[7:6] == 2'b00)
    else $error("random word upper bits not zero");
  a_random_load: assert property (
    QA_NEW_QUESTION |=> random_reg == $past(lfsr_reg))
    else $error("question not loaded");
  a_flag_clear: assert property (
    wr_low && REG_REQ.wdata[0] && !ST_LOW_PASS[0] |=> !st_low_reg[0])
    else $error("write one did not clear flag");
  a_flag_set_wins: assert property (
    ST_HIGH_PASS[7] |=> st_high_reg[7])
    else $error("pass event lost");
  a_unmapped_zero: assert property (
    REG_REQ.rd && REG_REQ.addr == 5'h0C |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_qa_fault: assert property (
    active_type == WD_QA && QA_TIMEOUT |=> WD_FAULT)
    else $error("timeout without fault");
  a_dither_follow: assert property (
    wr_timing ##1 !wr_timing |=> DITHER_OFF == timing_cfg_reg[DITHER_BIT])
    else $error("dither output stale");
  a_cfg_readback: assert property (
    wr_qa ##1 (REG_REQ.rd && REG_REQ.addr == ADDR_QA_CFG && !wr_qa)
    |=> REG_RDATA == ($past(REG_REQ.wdata, 2) & MASK_QA_CFG))
    else $error("config readback wrong");

  c_rst_pulse: cover property ($fell(POWER_ON_RESET_OUT_N));
  c_qa_fault: cover property (active_type == WD_QA ##1 WD_FAULT);
  c_flag_clear: cover property (wr_high ##1 st_high_reg == 8'h00);
endmodule

/* File: rtl/wcs_pkg.sv */
package wcs_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [4:0] ADDR_TIMING_CFG = 5'h09;
  localparam logic [4:0] ADDR_QA_CFG = 5'h0A;
  localparam logic [4:0] ADDR_RANDOM = 5'h0B;
  localparam logic [4:0] ADDR_ST_LOW = 5'h0D;
  localparam logic [4:0] ADDR_ST_HIGH = 5'h0E;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  // defined bits of the Q&A config and random word registers
  localparam logic [7:0] MASK_QA_CFG = 8'h7F;
  localparam logic [7:0] MASK_RANDOM = 8'h3F;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int WIN_SEL_LSB = 5;
  localparam int DITHER_BIT = 4;
  localparam int VALID_LSB = 2;
  localparam int EDGE_LSB = 0;
  localparam int RST_EN_BIT = 6;
  localparam int TOL_LSB = 4;
  localparam int QA_WIN_LSB = 0;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int POR_LOW_TIME_US = 2000;
  localparam int POR_LOW_CYCLES = POR_LOW_TIME_US * CLK_MHZ;
  localparam int EDGE_PERIOD_US = 2000;
  localparam int DELTA_BASE_US = 80;
  localparam int DELTA_STEP_US = 10;
  // random word generator seed, never zero
  localparam logic [5:0] LFSR_SEED = 6'h01;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    WD_PULSE = 2'b00,
    WD_WINDOW = 2'b10,
    WD_QA = 2'b11
  } wcs_wd_type_t;
  typedef enum logic [0:0] {
    RST_IDLE = 1'b0,
    RST_LOW = 1'b1
  } wcs_rst_state_t;
  // register access request from the serial port framing
  typedef struct packed {
    logic [4:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } wcs_req_t;
  // decoded settings for the watchdog engines, times in microseconds
  typedef struct packed {
    logic [16:0] win_fast_us;
    logic [16:0] win_slow_us;
    logic [3:0] valid_counts;
    logic [3:0] edge_counts;
    logic [15:0] nominal_us;
    logic [15:0] upper_us;
    logic [15:0] lower_us;
    logic [3:0] wrong_answer_tolerance;
    logic [18:0] qa_min_us;
    logic [18:0] qa_max_us;
  } wcs_timing_t;
endpackage

/* File: tb/wcs_host_model.sv */
`timescale 1ns/1ps
// host processor side of the register port: one strobe per access
module wcs_host_model
  import wcs_pkg::*;
(
  input wire logic CLK,
  output wcs_req_t req,
  input wire logic [7:0] rdata
);
  initial req = '0;
  // write strobe for one edge, then the lines go to junk so nothing lingers
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge CLK);
    req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge CLK);
    req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask
  // read strobe; data is taken just after the edge that accepts it
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge CLK);
    req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge CLK);
    req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'hA5};
    #1 d = rdata;
  endtask
  // write, then read the same place on the very next edge
  task automatic wr_rd_b2b(input logic [4:0] a, input logic [7:0] d,
                           output logic [7:0] q);
    @(posedge CLK);
    req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge CLK);
    req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge CLK);
    req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'hA5};
    #1 q = rdata;
  endtask
endmodule

/* File: tb/watchdog_config_selftest_regs_tb_top.sv */
`timescale 1ns/1ps
module watchdog_config_selftest_regs_tb_top;
  import wcs_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic clk = 1'b0;
  logic nrst = 1'b0;
  wcs_req_t req;
  logic [7:0] rdata;
  logic [1:0] type_sel = 2'b00;
  logic [2:0] up_d = 3'h0;
  logic [2:0] lo_d = 3'h0;
  logic new_q = 1'b0;
  logic wrong = 1'b0;
  logic tout = 1'b0;
  logic win_f = 1'b0;
  logic [7:0] st_lo = 8'h00;
  logic [7:0] st_hi = 8'h00;
  wcs_timing_t timing;
  logic dither;
  logic fault;
  logic por_n;
  int n_mismatch = 0;
  int check_count = 0;
  // expected decode tables, times in microseconds
  int fast_t [8] = '{500, 1000, 2000, 4000, 6000, 8000, 10000, 12500};
  int slow_t [8] = '{4000, 8000, 16000, 32000, 42000, 64000, 80000, 100000};
  int qa_t [16] = '{500, 1000, 2000, 4000, 8000, 12000, 16000, 24000,
                    32000, 40000, 64000, 72000, 80000, 96000, 128000, 144000};
  int tol_t [4] = '{0, 2, 4, 8};
  // ------------------------------------------------------------
  // design and host
  // ------------------------------------------------------------
  wcs_regs #(.RST_LOW_CYCLES(20)) DUT (
    .CLK(clk), .NRST(nrst), .REG_REQ(req), .REG_RDATA(rdata),
    .WATCHDOG_TYPE_SELECT(type_sel), .UPPER_LIMIT_DELTA(up_d),
    .LOWER_LIMIT_DELTA(lo_d), .QA_NEW_QUESTION(new_q),
    .QA_WRONG_ANSWER(wrong), .QA_TIMEOUT(tout), .WIN_FAULT(win_f),
    .ST_LOW_PASS(st_lo), .ST_HIGH_PASS(st_hi), .TIMING(timing),
    .DITHER_OFF(dither), .WD_FAULT(fault), .POWER_ON_RESET_OUT_N(por_n)
  );
  wcs_host_model host (.CLK(clk), .req(req), .rdata(rdata));
  // 200 MHz clock
  initial begin
    forever #2.5 clk = ~clk;
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  // write then read back one register
  task automatic wr_rd(input logic [4:0] a, input logic [7:0] d,
                       input logic [7:0] exp);
    logic [7:0] r;
    host.wr(a, d);
    host.rd(a, r);
    check(r, exp, "readback");
  endtask
  // one-cycle event pulse, then the fault output one edge later
  task automatic hit(input int k, input logic exp_f);
    @(posedge clk);
    case (k)
      0: wrong <= 1'b1;
      1: tout <= 1'b1;
      2: win_f <= 1'b1;
      default: new_q <= 1'b1;
    endcase
    @(posedge clk);
    {wrong, tout, win_f, new_q} <= 4'h0;
    #1 check(fault, exp_f, "fault");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // hang guard
  initial begin
    #400000;
    n_mismatch++;
    tally_and_finish();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0] r;
    int e;
    int lows;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    // reset values, unmapped place included
    wr_rd(5'h0C, 8'hFF, 8'h00);
    host.rd(ADDR_TIMING_CFG, r); check(r, 8'h00, "rst");
    host.rd(ADDR_QA_CFG, r); check(r, 8'h00, "rst");
    host.rd(ADDR_RANDOM, r); check(r, 8'h00, "rst");
    host.rd(ADDR_ST_LOW, r); check(r, 8'h00, "rst");
    host.rd(ADDR_ST_HIGH, r); check(r, 8'h00, "rst");
    // access kinds and undefined bits
    wr_rd(ADDR_TIMING_CFG, 8'hFF, 8'hFF);
    wr_rd(ADDR_QA_CFG, 8'hFF, 8'h7F);
    host.wr_rd_b2b(ADDR_QA_CFG, 8'hD5, r);
    check(r, 8'h55, "back to back");
    wr_rd(ADDR_RANDOM, 8'hFF, 8'h3F);
    wr_rd(ADDR_RANDOM, 8'h2A, 8'h2A);
    // dither control follows its bit
    host.wr(ADDR_TIMING_CFG, 8'h10);
    repeat (2) @(posedge clk);
    #1 check(dither, 1'b1, "dither");
    // window, validation, edge and delta decode over every code
    for (int i = 0; i < 8; i++) begin
      up_d <= 3'(i);
      lo_d <= ~3'(i);
      host.wr(ADDR_TIMING_CFG, {3'(i), 1'b0, 2'(i), 2'(i)});
      repeat (2) @(posedge clk);
      #1 e = 4 + 2 * (i % 4);
      check(dither, 1'b0, "dither");
      check(timing.win_fast_us, fast_t[i], "fast");
      check(timing.win_slow_us, slow_t[i], "slow");
      check(timing.valid_counts, 2 * (i % 4 + 1), "valid");
      check(timing.edge_counts, e, "edge");
      check(timing.nominal_us, e * 2000, "nominal");
      check(timing.upper_us, e * 2000 + 80 + 10 * i, "upper");
      check(timing.lower_us, e * 2000 - 150 + 10 * i, "lower");
    end
    // answer window and tolerance decode over every code
    for (int i = 0; i < 16; i++) begin
      host.wr(ADDR_QA_CFG, {2'b00, 2'(i), 4'(i)});
      repeat (2) @(posedge clk);
      #1 check(timing.qa_min_us, qa_t[i], "qa min");
      check(timing.qa_max_us, 2 * qa_t[i], "qa max");
      check(timing.wrong_answer_tolerance, tol_t[i % 4], "tol");
    end
    // self-test flags: set, partial clear, full clear
    @(posedge clk);
    st_lo <= 8'hA5;
    st_hi <= 8'hC3;
    @(posedge clk);
    st_lo <= 8'h00;
    st_hi <= 8'h00;
    host.rd(ADDR_ST_HIGH, r); check(r, 8'hC3, "st hi");
    wr_rd(ADDR_ST_LOW, 8'h05, 8'hA0);
    wr_rd(ADDR_ST_HIGH, 8'hFF, 8'h00);
    // Q&A: tolerance two, reset output enabled
    type_sel <= 2'b11;
    host.wr(ADDR_QA_CFG, 8'h50);
    hit(0, 1'b0);
    hit(0, 1'b0);
    hit(0, 1'b1);
    lows = 0;
    for (int j = 0; j < 100; j++) begin
      @(posedge clk);
      #1 if (!por_n) lows++;
      else if (lows > 0) break;
    end
    check(lows, 20, "reset low");
    hit(0, 1'b0);
    // tolerance zero, reset output disabled
    host.wr(ADDR_QA_CFG, 8'h00);
    hit(1, 1'b1);
    hit(0, 1'b1);
    repeat (3) @(posedge clk);
    #1 check(por_n, 1'b1, "reset held");
    // window mode, then pulse mode
    type_sel <= 2'b10;
    hit(2, 1'b1);
    hit(0, 1'b0);
    type_sel <= 2'b01;
    hit(2, 1'b0);
    hit(1, 1'b0);
    // new random question keeps its top bits clear
    host.wr(ADDR_RANDOM, 8'h00);
    hit(3, 1'b0);
    host.rd(ADDR_RANDOM, r);
    check(r[7:6], 2'b00, "rnd top");
    check(r != 8'h00, 1'b1, "rnd");
    // second reset in mid-run
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    host.rd(ADDR_RANDOM, r); check(r, 8'h00, "rst2");
    tally_and_finish();
  end
endmodule
